//--- rtl/eeo_event_output.sv
// External event output generator with its Avalon-MM register slave.
module eeo_event_output
   import eeo_pkg::*;
#(
   parameter int STATUS_W = 8,
   parameter int PULSE_LEN = PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire eeo_avs_req_t avs_req,
   output eeo_avs_rsp_t avs_rsp,
   input wire eeo_meas_t meas,
   input wire logic [STATUS_W-1:0] status_events,
   output logic event_output,
   output logic srq_bit,
   output logic irq
);

   localparam int HW = $clog2(PULSE_LEN + 2) + 1;

   logic [SEL_W-1:0] sel_reg;
   logic pol_reg;
   logic [STATUS_W-1:0] mask_reg;
   logic [STATUS_W-1:0] mask_next;
   logic srq_reg;
   logic [IRQ_W-1:0] irq_st_reg;
   logic [IRQ_W-1:0] irq_st_next;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_snap_reg;
   logic [IRQ_W-1:0] irq_events;
   logic irq_reg;
   logic wait_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rd_word;
   logic aperture_reg;
   logic event_output_reg;
   logic pulse_active;
   logic shown;
   logic wr_acc;
   logic rd_acc;
   logic wr_ctrl;
   logic once_trig;
   logic abort;
   logic clear_cmd;
   logic srq_hit;
   logic sel_trig;
   logic trig;
   logic [SEL_W-1:0] wr_sel;
   logic [HW-1:0] hcnt_reg;

   // ***************************************************************
   // Bus slave
   // ***************************************************************
   // One wait state on every access gives registered read data at no
   // cost in decode depth; the price is two cycles per transfer.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_reg <= WAIT_RESET;
      end else if ((avs_req.read || avs_req.write) && wait_reg) begin
         wait_reg <= 1'h0;
      end else begin
         wait_reg <= 1'h1;
      end
   end

   assign wr_acc = avs_req.write && !wait_reg;
   assign rd_acc = avs_req.read && !wait_reg;
   assign wr_sel = avs_req.writedata[CTRL_SEL_LSB +: SEL_W];
   assign wr_ctrl = wr_acc && (avs_req.address == OFS_CTRL) && avs_req.byteenable[0];
   assign once_trig = wr_ctrl && (wr_sel == EV_ONCE);
   assign abort = wr_ctrl && (wr_sel == EV_OFF);
   assign clear_cmd = wr_acc && (avs_req.address == OFS_CMD) && avs_req.byteenable[0]
                      && avs_req.writedata[CMD_CLEAR_BIT];

   // event selection sits below polarity in the settings word.
   always_comb begin
      rd_word = '0;
      case (avs_req.address)
         OFS_CTRL: begin
            rd_word[CTRL_SEL_LSB +: SEL_W] = sel_reg;
            rd_word[CTRL_POL_BIT] = pol_reg;
         end
         OFS_MASK: begin
            rd_word[STATUS_W-1:0] = mask_reg;
         end
         OFS_SRQ: begin
            rd_word[SRQ_FLAG_BIT] = srq_reg;
         end
         OFS_IRQ_ST: begin
            rd_word[IRQ_W-1:0] = irq_st_reg;
         end
         OFS_IRQ_MASK: begin
            rd_word[IRQ_W-1:0] = irq_mask_reg;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // The snapshot remembers which status bits were returned, so only those
   // are cleared when the read completes.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= '0;
         irq_snap_reg <= '0;
      end else if (avs_req.read && wait_reg) begin
         rdata_reg <= rd_word;
         irq_snap_reg <= (avs_req.address == OFS_IRQ_ST) ? irq_st_reg : '0;
      end
   end

   assign avs_rsp.readdata = rdata_reg;
   assign avs_rsp.waitrequest = wait_reg;

   // ***************************************************************
   // Settings
   // ***************************************************************
   // a one-shot request fires the pulse and stores the off code.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_reg <= SEL_RESET;
         pol_reg <= POL_RESET;
      end else if (wr_ctrl) begin
         sel_reg <= (wr_sel == EV_ONCE) ? EV_OFF : wr_sel;
         pol_reg <= avs_req.writedata[CTRL_POL_BIT];
      end
   end

   always_comb begin
      mask_next = mask_reg;
      for (int i = 0; i < STATUS_W; i++) begin
         if (wr_acc && (avs_req.address == OFS_MASK) && avs_req.byteenable[i / BYTE_W]) begin
            mask_next[i] = avs_req.writedata[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_reg <= '0;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // ***************************************************************
   // Service request
   // ***************************************************************
   assign srq_hit = |(status_events & mask_reg);

   // sticky until cleared; a new event in the clear cycle wins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         srq_reg <= 1'h0;
      end else if (srq_hit) begin
         srq_reg <= 1'h1;
      end else if (clear_cmd) begin
         srq_reg <= 1'h0;
      end
   end

   assign srq_bit = srq_reg;

   // ***************************************************************
   // Event selection and pulse timing
   // ***************************************************************
   // select the triggering event.
   always_comb begin
      case (sel_reg)
         EV_INPUT: sel_trig = meas.input_done_event;
         EV_BURST: sel_trig = meas.burst_done_event;
         EV_SRQ: sel_trig = srq_hit;
         EV_READ: sel_trig = meas.reading_done_event;
         default: sel_trig = 1'h0;
      endcase
   end

   // off and aperture codes never start a pulse except by command.
   assign trig = sel_trig || once_trig;

   // the timer fixes the width; a retrigger reloads it and stretches the pulse.
   eeo_pulse_timer #(
      .CYCLES(PULSE_LEN)
   ) u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .trigger(trig),
      .abort(abort),
      .active(pulse_active)
   );

   // The aperture level is delayed one stage so it keeps the same latency
   // as the pulse path.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aperture_reg <= 1'h0;
      end else begin
         aperture_reg <= meas.aperture_level_event;
      end
   end

   // the aperture code passes the level straight through.
   assign shown = (sel_reg == EV_APERTURE) ? aperture_reg : pulse_active;

   // polarity sets the active level of the leading edge.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         event_output_reg <= OUT_RESET;
      end else begin
         event_output_reg <= pol_reg ? shown : !shown;
      end
   end

   assign event_output = event_output_reg;

   // ***************************************************************
   // Interrupts
   // ***************************************************************
   always_comb begin
      irq_events = '0;
      irq_events[IRQ_PULSE_BIT] = trig;
      irq_events[IRQ_SRQ_BIT] = srq_hit && !srq_reg;
      irq_st_next = irq_st_reg;
      if (rd_acc && (avs_req.address == OFS_IRQ_ST)) begin
         irq_st_next = irq_st_reg & ~irq_snap_reg;
      end
      irq_st_next = irq_st_next | irq_events;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_st_reg <= '0;
         irq_mask_reg <= '0;
         irq_reg <= 1'h0;
      end else begin
         irq_st_reg <= irq_st_next;
         irq_reg <= |(irq_st_next & irq_mask_reg);
         if (wr_acc && (avs_req.address == OFS_IRQ_MASK) && avs_req.byteenable[0]) begin
            irq_mask_reg <= avs_req.writedata[IRQ_W-1:0];
         end
      end
   end

   assign irq = irq_reg;

   // ***************************************************************
   // Checks
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hcnt_reg <= '0;
      end else if (trig) begin
         hcnt_reg <= HW'(1);
      end else if (pulse_active) begin
         hcnt_reg <= hcnt_reg + HW'(1);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_off_no_start: assert property ((sel_reg == EV_OFF && !pulse_active && !once_trig)
      |=> !pulse_active)
      else $error("pulse started while output disabled");

   a_input_pulse: assert property ((sel_reg == EV_INPUT && meas.input_done_event && !abort)
      |=> pulse_active)
      else $error("input done event gave no pulse");

   a_once_then_off: assert property (once_trig |=> (sel_reg == EV_OFF && pulse_active)
      ##1 pulse_active)
      else $error("one-shot command did not pulse and return to off");

   a_aperture_follows: assert property (($past(sel_reg) == EV_APERTURE)
      |-> (event_output_reg == ($past(pol_reg) ~^ $past(meas.aperture_level_event, 2))))
      else $error("output does not follow aperture level");

   a_burst_pulse: assert property ((sel_reg == EV_BURST && meas.burst_done_event && !abort)
      |=> pulse_active)
      else $error("burst done event gave no pulse");

   a_srq_pulse: assert property ((sel_reg == EV_SRQ && srq_hit && srq_reg && !abort)
      |=> pulse_active)
      else $error("enabled status event with request set gave no pulse");

   a_reading_pulse: assert property ((sel_reg == EV_READ && meas.reading_done_event && !abort)
      |=> pulse_active)
      else $error("reading done event gave no pulse");

   a_idle_level: assert property ((!pulse_active && sel_reg != EV_APERTURE)
      |=> (event_output_reg == !$past(pol_reg)))
      else $error("idle output not at inactive level");

   a_pulse_width: assert property (($fell(pulse_active) && !$past(abort))
      |-> ($past(hcnt_reg) == HW'(PULSE_LEN)))
      else $error("pulse width differs from one microsecond");

   a_lead_edge: assert property ((trig && !abort) ##1 (sel_reg != EV_APERTURE && !abort)
      |=> (event_output_reg == $past(pol_reg)))
      else $error("output not active two cycles after event");

   a_srq_sticky: assert property ((srq_reg && !clear_cmd) |=> srq_reg)
      else $error("service request bit dropped without clear");

   a_ctrl_readback: assert property ((rd_acc && avs_req.address == OFS_CTRL)
      |-> (rdata_reg[CTRL_SEL_LSB +: SEL_W] == $past(sel_reg)
           && rdata_reg[CTRL_POL_BIT] == $past(pol_reg)))
      else $error("settings readback wrong");

   a_retrigger_kept: assert property ((trig && pulse_active && !abort)
      |=> (pulse_active && hcnt_reg == HW'(1)))
      else $error("retrigger during pulse was lost");

endmodule

//--- rtl/eeo_pkg.sv
// Shared constants, register map and carrier types for the event output block.
package eeo_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int PULSE_WIDTH_NS = 1000;
   // A least width, so the count rounds up to whole cycles.
   localparam int PULSE_CYCLES = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ***************************************************************
   // Event selection and polarity codes
   // ***************************************************************
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] EV_OFF = 3'h0;
   localparam logic [SEL_W-1:0] EV_INPUT = 3'h1;
   localparam logic [SEL_W-1:0] EV_ONCE = 3'h2;
   localparam logic [SEL_W-1:0] EV_APERTURE = 3'h3;
   localparam logic [SEL_W-1:0] EV_BURST = 3'h4;
   localparam logic [SEL_W-1:0] EV_SRQ = 3'h5;
   localparam logic [SEL_W-1:0] EV_READ = 3'h6;
   localparam logic POL_ACTIVE_LOW = 1'h0;
   localparam logic POL_ACTIVE_HIGH = 1'h1;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [SEL_W-1:0] SEL_RESET = EV_INPUT;
   localparam logic POL_RESET = POL_ACTIVE_LOW;
   localparam logic OUT_RESET = ~POL_RESET;
   localparam logic WAIT_RESET = 1'h1;

   // ***************************************************************
   // Register map (byte addresses) and field positions
   // ***************************************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_MASK = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_SRQ = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CMD = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h14;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_POL_BIT = 4;
   localparam int CMD_CLEAR_BIT = 0;
   localparam int SRQ_FLAG_BIT = 0;
   localparam int IRQ_W = 2;
   localparam int IRQ_PULSE_BIT = 0;
   localparam int IRQ_SRQ_BIT = 1;
   localparam int BYTE_W = 8;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [DATA_W-1:0] writedata;
      logic [BE_W-1:0] byteenable;
   } eeo_avs_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic waitrequest;
   } eeo_avs_rsp_t;

   typedef struct packed {
      logic input_done_event;
      logic aperture_level_event;
      logic burst_done_event;
      logic reading_done_event;
   } eeo_meas_t;

endpackage

//--- rtl/eeo_pulse_timer.sv
// Retriggerable one-shot that sets the width of every output pulse except under the aperture code, which passes the level through.
module eeo_pulse_timer #(
   parameter int CYCLES = 40
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic trigger,
   input wire logic abort,
   output logic active
);

   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

   logic [CW-1:0] cnt_reg;
   logic active_reg;

   // ***************************************************************
   // Counter
   // ***************************************************************
   // restart on every trigger unless an abort comes in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         active_reg <= 1'h0;
         cnt_reg <= '0;
      end else if (abort) begin
         active_reg <= 1'h0;
         cnt_reg <= '0;
      end else if (trigger) begin
         // A trigger during a pulse reloads the count, so the pulse is stretched.
         active_reg <= 1'h1;
         cnt_reg <= CW'(CYCLES - 1);
      end else if (active_reg) begin
         if (cnt_reg == '0) begin
            active_reg <= 1'h0;
         end else begin
            cnt_reg <= cnt_reg - CW'(1);
         end
      end
   end

   assign active = active_reg;

endmodule

//--- sim/eeo_receiver.sv
// Behavioural model of the equipment that receives the event output line.
module eeo_receiver (
   input wire logic clk,
   input wire logic line,
   input wire logic pol,
   output int edges,
   output int last_width
);
   timeunit 1ns;
   timeprecision 100ps;
   int run;
   // The line is sampled mid-cycle, so the count is whole cycles of the driver.
   // leading edge marks
   always @(negedge clk) begin
      if (line === pol) begin
         if (run == 0) edges <= edges + 1;
         run <= run + 1;
      end else begin
         if (run != 0) last_width <= run;
         run <= 0;
      end
   end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the event output block.
module testbench
   import eeo_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pol = 1'b0;
   eeo_avs_req_t req = '0;
   eeo_avs_rsp_t rsp;
   eeo_meas_t meas = '0;
   logic [7:0] st = 8'h00;
   logic event_output;
   logic srq_bit;
   logic irq;
   logic [DATA_W-1:0] rd;
   int edges;
   int last_width;
   int num_errors = 0;
   int total_checks = 0;

   always #12.5 clk = ~clk;

   eeo_event_output i_eeo_event_output (
      .clk(clk),
      .sys_rst(sys_rst),
      .avs_req(req),
      .avs_rsp(rsp),
      .meas(meas),
      .status_events(st),
      .event_output(event_output),
      .srq_bit(srq_bit),
      .irq(irq)
   );

   eeo_receiver i_eeo_receiver (
      .clk(clk),
      .line(event_output),
      .pol(pol),
      .edges(edges),
      .last_width(last_width)
   );

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Each access starts at an edge, so a release and a new request never share a step.
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req.address <= a;
      req.write <= wr;
      req.read <= ~wr;
      req.writedata <= d;
      req.byteenable <= 4'hF;
      // Only the watchdog ends a wait that never sees waitrequest low.
      do begin
         @(posedge clk);
      end while (rsp.waitrequest !== 1'b0);
      chk_bit(rsp.waitrequest, 1'b0);
      rd = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk_word(rd, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic setup(input logic [DATA_W-1:0] d);
      wr(OFS_CTRL, d);
      pol = d[CTRL_POL_BIT];
      settle(4);
   endtask

   task automatic fire(input logic [3:0] m, input logic [7:0] s);
      @(posedge clk);
      meas <= eeo_meas_t'(m);
      st <= s;
      @(posedge clk);
      meas <= eeo_meas_t'(4'h0);
      st <= 8'h00;
   endtask

   task automatic expect_quiet(input int n);
      int e0;
      e0 = edges;
      settle(n);
      chk_word(32'(edges - e0), 32'h00000000);
      chk_bit(event_output, ~pol);
   endtask

   // A negative lead skips the check of the delay to the leading edge.
   task automatic expect_pulse(input int lead, input int width);
      int n;
      int e0;
      e0 = edges;
      n = 0;
      while (event_output !== pol && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (lead >= 0) chk_word(32'(n), 32'(lead));
      n = 0;
      while (event_output === pol && n < 2000) begin
         @(negedge clk);
         n++;
      end
      settle(1);
      chk_word(32'(last_width), 32'(width));
      chk_word(32'(edges - e0), 32'h00000001);
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_reset;
      chk_bit(event_output, ~POL_RESET);
      chk_bit(srq_bit, 1'b0);
      rdchk(OFS_CTRL, 32'h00000001);
      rdchk(OFS_MASK, 32'h00000000);
      rdchk(OFS_SRQ, 32'h00000000);
      rdchk(OFS_CMD, 32'h00000000);
      rdchk(OFS_IRQ_MASK, 32'h00000000);
      rdchk(5'h18, 32'h00000000);
      rdchk(5'h02, 32'h00000000);
      $display("test reset done");
   endtask

   task automatic t_events;
      logic [2:0] code [3];
      logic [3:0] trig [3];
      logic [DATA_W-1:0] c;
      code = '{EV_INPUT, EV_BURST, EV_READ};
      trig = '{4'h8, 4'h2, 4'h1};
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 3; i++) begin
            c = 32'(code[i]) | (32'(p) << CTRL_POL_BIT);
            setup(c);
            rdchk(OFS_CTRL, c);
            chk_bit(event_output, ~pol);
            fire(~trig[i], 8'hFF);
            expect_quiet(PULSE_CYCLES + 8);
            fire(trig[i], 8'h00);
            expect_pulse(2, PULSE_CYCLES);
         end
      end
      $display("test events done");
   endtask

   task automatic t_off;
      setup(32'h00000010);
      fire(4'hB, 8'hFF);
      expect_quiet(PULSE_CYCLES);
      setup(32'h00000017);
      fire(4'hB, 8'hFF);
      expect_quiet(PULSE_CYCLES);
      setup(32'h00000016);
      fire(4'h1, 8'h00);
      settle(5);
      wr(OFS_CTRL, 32'h00000010);
      settle(4);
      chk_bit(event_output, 1'b0);
      chk_bit(last_width < PULSE_CYCLES, 1'b1);
      $display("test off done");
   endtask

   task automatic t_once;
      setup(32'h00000000);
      wr(OFS_CTRL, 32'h00000002);
      expect_pulse(-1, PULSE_CYCLES);
      rdchk(OFS_CTRL, 32'h00000000);
      fire(4'hF, 8'h00);
      expect_quiet(PULSE_CYCLES + 8);
      $display("test once done");
   endtask

   task automatic t_aperture_level_event;
      setup(32'h00000013);
      fork
         begin
            @(posedge clk);
            meas.aperture_level_event <= 1'b1;
            repeat (10) @(posedge clk);
            meas.aperture_level_event <= 1'b0;
         end
         expect_pulse(-1, 10);
      join
      $display("test aperture done");
   endtask

   task automatic t_srq;
      wr(OFS_MASK, 32'h00000004);
      setup(32'h00000015);
      fire(4'h0, 8'h08);
      expect_quiet(PULSE_CYCLES);
      chk_bit(srq_bit, 1'b0);
      for (int i = 0; i < 2; i++) begin
         fire(4'h0, 8'h04);
         expect_pulse(2, PULSE_CYCLES);
         chk_bit(srq_bit, 1'b1);
      end
      rdchk(OFS_SRQ, 32'h00000001);
      wr(OFS_CMD, 32'h00000001);
      settle(2);
      chk_bit(srq_bit, 1'b0);
      $display("test service request done");
   endtask

   task automatic t_retrig;
      setup(32'h00000016);
      fork
         begin
            fire(4'h1, 8'h00);
            repeat (8) @(posedge clk);
            fire(4'h1, 8'h00);
         end
         expect_pulse(-1, PULSE_CYCLES + 10);
      join
      $display("test retrigger done");
   endtask

   task automatic t_irq;
      wr(OFS_IRQ_MASK, 32'h00000001);
      rdchk(OFS_IRQ_ST, 32'h00000003);
      settle(2);
      chk_bit(irq, 1'b0);
      fire(4'h1, 8'h00);
      settle(4);
      chk_bit(irq, 1'b1);
      rdchk(OFS_IRQ_ST, 32'h00000001);
      settle(PULSE_CYCLES);
      chk_bit(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h00000000);
      fire(4'h1, 8'h00);
      settle(4);
      chk_bit(irq, 1'b0);
      rdchk(OFS_IRQ_ST, 32'h00000001);
      $display("test interrupt done");
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 25);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_events();
      t_off();
      t_once();
      t_aperture_level_event();
      t_srq();
      t_retrig();
      t_irq();
      tally_and_finish();
   end
endmodule
